/* src/reset_cause_pkg.sv */
package reset_cause_pkg;
    localparam logic [31:0] ADDR_MEMORY_MAP_CONTROL = 32'hffff0220;
    localparam logic [31:0] ADDR_RESET_CAUSE_STATUS = 32'hffff0230;
    localparam logic [31:0] ADDR_RESET_CAUSE_CLEAR = 32'hffff0234;
    localparam logic [31:0] ADDR_RESET_CONTROL = 32'hffff0238;
    localparam int BIT_POR = 0;
    localparam int BIT_WDOG = 1;
    localparam int BIT_SOFT = 2;
    localparam int BIT_EXT = 3;
    localparam int BIT_REMAP = 0;
    localparam int BIT_LVF_ENABLE = 2;
    localparam int BIT_LVF_STATUS = 6;
    localparam int BIT_DOWNLOAD = 0;
    localparam logic [3:0] CAUSE_RESET = 4'h0;
    localparam logic [7:0] MAP_RESET = 8'h00;
    localparam real RESET_PULSE_NS = 40.0;
    localparam real CLOCK_NS = 10.0;
    localparam int RESET_PULSE_CYCLES = int'(RESET_PULSE_NS / CLOCK_NS);

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic por;
        logic wdog;
        logic ext;
    } reset_src_t;
endpackage

/* src/reset_pulse_gen.sv */
`timescale 1ns/100ps
module reset_pulse_gen
    import reset_cause_pkg::*;
#(
    parameter int CYCLES = RESET_PULSE_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    output logic busy
);
    logic [7:0] count_q;
    logic [7:0] count_d;

    assign count_d = start ? 8'(CYCLES) : (count_q != 8'h00 ? count_q - 8'h01 : 8'h00);
    assign busy = (count_q != 8'h00);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_q <= 8'h00;
        end else begin
            count_q <= count_d;
        end
    end
endmodule

/* src/reset_cause_and_remap.sv */
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
// Functional notes
// - Setting remap bit puts SRAM at address zero.
// - Any reset clears the remap bit, flash returns to zero.
// - Four reset sources distinguished and recorded.
// - External pin reset sets status bit three.
// - Watchdog reset sets status bit one.
// - Power-on reset sets status bit zero.
// - Writing one to status bit two starts a software reset, bit stays set.
// - Clear register ones clear matching status bits.
// - Status bits seven to four read zero.
// - Clear write leaving software bit set retriggers software reset.
// - Every reset resets block registers except status; watchdog only on power-on.
// - SRAM survives non-power-on resets, invalid after reset following download.
// - After power-on, SRAM valid only if flag enabled and flag set.
// - Map control is 8-bit read/write at 0xffff0220, bit zero remaps.
module reset_cause_and_remap
    import reset_cause_pkg::*;
#(
    parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic por_event,
    input wire logic wdog_event,
    input wire logic ext_event,
    input wire logic [7:0] high_voltage_status,
    input wire logic [7:0] high_voltage_config,
    input wire logic download_done,
    output logic system_reset,
    output logic watchdog_reset,
    output logic sram_at_zero,
    output logic sram_valid
);
    apb_req_t req;
    reset_src_t src;
    logic [3:0] cause_q;
    logic [3:0] cause_d;
    logic [7:0] map_q;
    logic [7:0] map_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic download_q;
    logic download_d;
    logic valid_q;
    logic valid_d;
    logic wdog_q;
    logic pulse_busy;
    logic soft_start;
    logic any_reset;
    logic access;
    logic wr_status;
    logic wr_clear;
    logic wr_map;
    logic wr_ctrl;
    logic mapped;
    logic [3:0] set_bits;
    logic [3:0] clr_bits;
    logic lvf_ok;
    logic start_any;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
        return a[31:2] == b[31:2];
    endfunction

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign src = '{por: por_event, wdog: wdog_event, ext: ext_event};
    // One-cycle zero-wait slave
    assign access = req.psel && req.penable;
    assign mapped = hit(req.paddr, ADDR_MEMORY_MAP_CONTROL)
        || hit(req.paddr, ADDR_RESET_CAUSE_STATUS)
        || hit(req.paddr, ADDR_RESET_CAUSE_CLEAR)
        || hit(req.paddr, ADDR_RESET_CONTROL);
    assign wr_status = access && req.pwrite && hit(req.paddr, ADDR_RESET_CAUSE_STATUS);
    assign wr_clear = access && req.pwrite && hit(req.paddr, ADDR_RESET_CAUSE_CLEAR);
    assign wr_map = access && req.pwrite && hit(req.paddr, ADDR_MEMORY_MAP_CONTROL);
    assign wr_ctrl = access && req.pwrite && hit(req.paddr, ADDR_RESET_CONTROL);
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_q;

    // Software reset request and re-trigger
    assign soft_start = (wr_status && req.pwdata[BIT_SOFT])
        || (wr_clear && cause_q[BIT_SOFT] && !req.pwdata[BIT_SOFT]);

    assign set_bits[BIT_POR] = src.por;
    assign set_bits[BIT_WDOG] = src.wdog;
    assign set_bits[BIT_SOFT] = soft_start;
    assign set_bits[BIT_EXT] = src.ext;
    assign clr_bits = wr_clear ? req.pwdata[3:0] : 4'h0;

    // Power-on wipes older causes; others accumulate; set beats clear
    assign cause_d = src.por ? set_bits : ((cause_q & ~clr_bits) | set_bits);

    assign start_any = soft_start || src.por || src.wdog || src.ext;
    assign any_reset = start_any || pulse_busy;
    // Reserved map bits kept zero whatever is written
    assign map_d = any_reset ? MAP_RESET
        : (wr_map ? {7'h00, req.pwdata[BIT_REMAP]} : map_q);

    assign download_d = any_reset ? 1'b0
        : (wr_ctrl ? (req.pwdata[BIT_DOWNLOAD] || download_done) // Set beats clear
        : (download_q || download_done));
    assign lvf_ok = high_voltage_config[BIT_LVF_ENABLE] && high_voltage_status[BIT_LVF_STATUS];
    assign valid_d = src.por ? lvf_ok
        : ((any_reset && download_q) ? 1'b0 : valid_q);

    always_comb begin
        prdata_d = 32'h0000_0000;
        if (req.psel && !req.penable && !req.pwrite) begin
            if (hit(req.paddr, ADDR_RESET_CAUSE_STATUS)) begin
                prdata_d = {28'h0, cause_q};
            end else if (hit(req.paddr, ADDR_MEMORY_MAP_CONTROL)) begin
                prdata_d = {24'h0, map_q};
            end else if (hit(req.paddr, ADDR_RESET_CONTROL)) begin
                prdata_d = {31'h0, download_q};
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cause_q <= 4'(1 << BIT_POR);
            map_q <= MAP_RESET;
            prdata_q <= 32'h0000_0000;
            download_q <= 1'b0;
            valid_q <= 1'b0;
            wdog_q <= 1'b1;
        end else begin
            cause_q <= cause_d;
            map_q <= map_d;
            prdata_q <= prdata_d;
            download_q <= download_d;
            valid_q <= valid_d;
            wdog_q <= src.por;
        end
    end

    reset_pulse_gen #(
        .CYCLES(PULSE_CYCLES)
    ) u_pulse (
        .clock(clock),
        .resetn(resetn),
        .start(start_any),
        .busy(pulse_busy)
    );

    assign system_reset = pulse_busy;
    assign watchdog_reset = wdog_q;
    assign sram_at_zero = map_q[BIT_REMAP];
    assign sram_valid = valid_q;

    AST_EXT_SETS: assert property (@(posedge clock) disable iff (!resetn)
        ext_event |=> cause_q[BIT_EXT]) else $error("ext cause not set");
    AST_WDOG_SETS: assert property (@(posedge clock) disable iff (!resetn)
        wdog_event |=> cause_q[BIT_WDOG]) else $error("wdog cause not set");
    AST_POR_SETS: assert property (@(posedge clock) disable iff (!resetn)
        por_event |=> cause_q == {$past(ext_event), $past(soft_start), $past(wdog_event), 1'b1})
        else $error("por cause wrong");
    AST_SOFT: assert property (@(posedge clock) disable iff (!resetn)
        (wr_status && pwdata[BIT_SOFT]) |=> cause_q[BIT_SOFT] && system_reset)
        else $error("soft reset missing");
    AST_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
        (wr_clear && pwdata[BIT_WDOG] && !wdog_event && !por_event) |=> !cause_q[BIT_WDOG])
        else $error("clear failed");
    AST_RETRIGGER: assert property (@(posedge clock) disable iff (!resetn)
        (wr_clear && cause_q[BIT_SOFT] && !pwdata[BIT_SOFT]) |=> system_reset [*4])
        else $error("no retrigger");
    AST_REMAP_CLR: assert property (@(posedge clock) disable iff (!resetn)
        system_reset |=> !sram_at_zero) else $error("remap not cleared");
    AST_UPPER_ZERO: assert property (@(posedge clock) disable iff (!resetn)
        prdata[31:4] == 28'h0 || $past(paddr) != ADDR_RESET_CAUSE_STATUS)
        else $error("upper bits set");
    AST_LVF: assert property (@(posedge clock) disable iff (!resetn)
        por_event |=> sram_valid == $past(lvf_ok)) else $error("sram valid wrong");

    // Building blocks for the multi-step checks below
    sequence seq_read_setup(logic [31:0] a);
        psel && !penable && !pwrite && hit(paddr, a);
    endsequence

    sequence seq_no_start;
        !start_any [*5];
    endsequence

    sequence seq_quiet_cycle;
        !por_event && !wr_clear;
    endsequence

    // Bus side
    AST_PREADY_HIGH: assert property (@(posedge clock) disable iff (!resetn)
        pready)
        else $error("ready low");

    AST_SLVERR_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        !psel |-> !pslverr)
        else $error("error outside access");

    AST_SLVERR_MAPPED: assert property (@(posedge clock) disable iff (!resetn)
        (psel && penable && hit(paddr, ADDR_MEMORY_MAP_CONTROL)) |-> !pslverr)
        else $error("error on mapped register");

    AST_PRDATA_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        !psel |=> prdata == 32'h0000_0000)
        else $error("read data not idle");

    AST_STATUS_READ: assert property (@(posedge clock) disable iff (!resetn)
        seq_read_setup(ADDR_RESET_CAUSE_STATUS) |=> prdata == {28'h0, $past(cause_q)})
        else $error("status read wrong");

    AST_MAP_READ: assert property (@(posedge clock) disable iff (!resetn)
        seq_read_setup(ADDR_MEMORY_MAP_CONTROL) |=> prdata == {24'h0, $past(map_q)})
        else $error("map read wrong");

    // Write-only register must never leak state
    AST_CLEAR_READ_ZERO: assert property (@(posedge clock) disable iff (!resetn)
        seq_read_setup(ADDR_RESET_CAUSE_CLEAR) |=> prdata == 32'h0000_0000)
        else $error("clear register readable");

    // Remap control
    AST_MAP_RESERVED: assert property (@(posedge clock) disable iff (!resetn)
        map_q[7:1] == 7'h00)
        else $error("reserved map bits set");

    AST_MAP_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        (wr_map && !any_reset) |=> sram_at_zero == $past(pwdata[BIT_REMAP]))
        else $error("remap write lost");

    AST_MAP_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        (!wr_map && !any_reset) |=> $stable(map_q))
        else $error("map changed unasked");

    AST_ANY_RESET_CLR: assert property (@(posedge clock) disable iff (!resetn)
        any_reset |=> map_q == MAP_RESET)
        else $error("reset left remap set");

    // Reset pulse shape; a new source restarts the count
    AST_PULSE_FOLLOWS: assert property (@(posedge clock) disable iff (!resetn)
        start_any |=> system_reset)
        else $error("no reset pulse");

    AST_PULSE_ENDS: assert property (@(posedge clock) disable iff (!resetn)
        seq_no_start |-> !system_reset)
        else $error("reset pulse too long");

    AST_PULSE_CAUSED: assert property (@(posedge clock) disable iff (!resetn)
        $rose(system_reset) |-> $past(start_any))
        else $error("reset pulse without source");

    AST_WDOG_POR: assert property (@(posedge clock) disable iff (!resetn)
        por_event |=> watchdog_reset)
        else $error("watchdog not reset on power-on");

    AST_WDOG_ONLY_POR: assert property (@(posedge clock) disable iff (!resetn)
        (wdog_event && !por_event) ##1 !por_event |=> !watchdog_reset)
        else $error("watchdog reset without power-on");

    // Cause bits
    AST_SOFT_ROSE: assert property (@(posedge clock) disable iff (!resetn)
        $rose(cause_q[BIT_SOFT]) |-> $past(soft_start))
        else $error("soft cause without request");

    AST_EXT_ROSE: assert property (@(posedge clock) disable iff (!resetn)
        $rose(cause_q[BIT_EXT]) |-> $past(ext_event))
        else $error("ext cause without event");

    AST_WDOG_ROSE: assert property (@(posedge clock) disable iff (!resetn)
        $rose(cause_q[BIT_WDOG]) |-> $past(wdog_event))
        else $error("wdog cause without event");

    AST_CAUSE_KEEP: assert property (@(posedge clock) disable iff (!resetn)
        seq_quiet_cycle |=> (cause_q & $past(cause_q)) == $past(cause_q))
        else $error("cause bit lost");

    AST_EXT_CLEARS: assert property (@(posedge clock) disable iff (!resetn)
        (wr_clear && pwdata[BIT_EXT] && !ext_event) |=> !cause_q[BIT_EXT])
        else $error("ext cause not cleared");

    // Event and clear in one cycle: the event is kept
    AST_SET_BEATS_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
        (wdog_event && wr_clear && pwdata[BIT_WDOG]) |=> cause_q[BIT_WDOG])
        else $error("clear beat event");

    AST_POR_WIPES: assert property (@(posedge clock) disable iff (!resetn)
        (por_event && !wdog_event) |=> !cause_q[BIT_WDOG])
        else $error("old cause kept over power-on");

    // SRAM validity tracking
    AST_VALID_DOWNLOAD: assert property (@(posedge clock) disable iff (!resetn)
        (any_reset && download_q && !por_event) |=> !sram_valid)
        else $error("sram valid after download");

    AST_VALID_KEEP: assert property (@(posedge clock) disable iff (!resetn)
        (!por_event && !download_q) |=> $stable(sram_valid))
        else $error("sram valid changed");

    AST_DOWNLOAD_SET: assert property (@(posedge clock) disable iff (!resetn)
        (download_done && !any_reset) |=> download_q)
        else $error("download marker lost");

    AST_DOWNLOAD_CLR: assert property (@(posedge clock) disable iff (!resetn)
        any_reset |=> !download_q)
        else $error("download marker kept over reset");
endmodule

/* testbench/tb_reset_cause_and_remap.sv */
`timescale 1ns/100ps
module tb_reset_cause_and_remap
    import reset_cause_pkg::*;
;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, system_reset, watchdog_reset, sram_at_zero, sram_valid;
    logic por_event = 1'b0, wdog_event = 1'b0, ext_event = 1'b0, download_done = 1'b0;
    logic [7:0] high_voltage_status = 8'h00, high_voltage_config = 8'h00;
    int num_errors = 0;
    int total_checks = 0;
    reset_cause_and_remap #(.PULSE_CYCLES(4)) reset_cause_and_remap_i (.clock(clock),
        .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .por_event(por_event), .wdog_event(wdog_event), .ext_event(ext_event),
        .high_voltage_status(high_voltage_status), .high_voltage_config(high_voltage_config),
        .download_done(download_done), .system_reset(system_reset),
        .watchdog_reset(watchdog_reset), .sram_at_zero(sram_at_zero), .sram_valid(sram_valid));
    always #5 clock = ~clock;
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic expire();
        num_errors++;
        $display("Error wait expired");
        close_out();
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Request held until pready is sampled high; data taken at that edge only
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 16) expire();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(name, q, exp);
    endtask
    task automatic wait_rst();
        int n;
        for (n = 0; n < 20 && system_reset !== 1'b1; n++) @(posedge clock);
        if (system_reset !== 1'b1) expire();
        for (n = 0; n < 20 && system_reset !== 1'b0; n++) @(posedge clock);
        if (system_reset !== 1'b0) expire();
        repeat (2) @(posedge clock);
    endtask
    // Bit order is por, watchdog, external pin
    task automatic pulse(input logic [2:0] s);
        @(posedge clock);
        {por_event, wdog_event, ext_event} <= s;
        @(posedge clock);
        {por_event, wdog_event, ext_event} <= 3'b000;
        wait_rst();
    endtask
    task automatic t_remap();
        rd("status", ADDR_RESET_CAUSE_STATUS, 32'h01);
        wr(ADDR_MEMORY_MAP_CONTROL, 32'h01);
        rd("map", ADDR_MEMORY_MAP_CONTROL, 32'h01);
        chk("sram_at_zero", sram_at_zero, 1'b1);
        pulse(3'b001);
        chk("sram_at_zero", sram_at_zero, 1'b0);
        rd("map", ADDR_MEMORY_MAP_CONTROL, 32'h00);
        rd("status", ADDR_RESET_CAUSE_STATUS, 32'h09);
    endtask
    task automatic t_clear();
        wr(ADDR_RESET_CAUSE_CLEAR, 32'h08);
        rd("status", ADDR_RESET_CAUSE_STATUS, 32'h01);
        wr(ADDR_RESET_CAUSE_CLEAR, 32'hff);
        wr(ADDR_RESET_CAUSE_STATUS, 32'hf0);
        rd("status", ADDR_RESET_CAUSE_STATUS, 32'h00);
        pulse(3'b010);
        rd("status", ADDR_RESET_CAUSE_STATUS, 32'h02);
        chk("watchdog_reset", watchdog_reset, 1'b0);
    endtask
    task automatic t_soft();
        wr(ADDR_RESET_CAUSE_STATUS, 32'h04);
        wait_rst();
        rd("status", ADDR_RESET_CAUSE_STATUS, 32'h06);
        wr(ADDR_RESET_CAUSE_CLEAR, 32'h02);
        wait_rst();
        rd("status", ADDR_RESET_CAUSE_STATUS, 32'h04);
        wr(ADDR_RESET_CAUSE_CLEAR, 32'h04);
        repeat (6) @(posedge clock);
        chk("system_reset", system_reset, 1'b0);
        rd("status", ADDR_RESET_CAUSE_STATUS, 32'h00);
    endtask
    task automatic t_sram();
        logic [31:0] q;
        logic e;
        high_voltage_config <= 8'h04;
        high_voltage_status <= 8'h40;
        pulse(3'b101);
        rd("status", ADDR_RESET_CAUSE_STATUS, 32'h09);
        chk("sram_valid", sram_valid, 1'b1);
        pulse(3'b001);
        chk("sram_valid", sram_valid, 1'b1);
        @(posedge clock);
        download_done <= 1'b1;
        @(posedge clock);
        download_done <= 1'b0;
        rd("download", ADDR_RESET_CONTROL, 32'h01);
        pulse(3'b001);
        chk("sram_valid", sram_valid, 1'b0);
        high_voltage_status <= 8'h00;
        pulse(3'b100);
        chk("sram_valid", sram_valid, 1'b0);
        apb(1'b0, 32'hffff0300, 32'h0, q, e);
        chk("pslverr", e, 1'b1);
        chk("unmapped", q, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        chk("watchdog_reset", watchdog_reset, 1'b1);
        resetn <= 1'b1;
        t_remap();
        t_clear();
        t_soft();
        t_sram();
        close_out();
    end
endmodule
